// ===== pkg/pmr_pkg.sv
// Constants for the power-on and supply-monitor reset sequencer.
package pmr_pkg;
  localparam int unsigned CLK_HZ               = 25000000;
  localparam int unsigned POR_DELAY_NS         = 300000;
  localparam int unsigned POR_DELAY_CYC        = (POR_DELAY_NS / 40 > 0) ? POR_DELAY_NS / 40 : 1;
  localparam int unsigned WDT_DIV              = 12;
  localparam int unsigned SYNC_STAGES          = 3;
  localparam logic [3:0]  ADDR_MON_CTRL        = 4'h0;
  localparam logic [3:0]  ADDR_RST_SRC         = 4'h1;
  localparam logic [3:0]  ADDR_SW_RESET        = 4'h2;
  localparam logic [3:0]  ADDR_RAM_ADDR        = 4'h3;
  localparam logic [3:0]  ADDR_RAM_DATA        = 4'h4;
  localparam logic [3:0]  ADDR_STATUS          = 4'h5;
  localparam int unsigned MON_EN_BIT           = 7;
  localparam int unsigned MON_STAT_BIT         = 6;
  localparam int unsigned POR_FLAG_BIT         = 1;
  localparam int unsigned SW_RST_BIT           = 4;
  localparam logic [7:0]  PORT_LATCH_RST       = 8'hff;
  localparam logic [15:0] PC_RST               = 16'h0000;
  localparam logic [7:0]  SP_RST               = 8'h07;
  localparam logic [1:0]  CLK_SRC_INT_OSC      = 2'h0;
  typedef enum logic [1:0] {PMR_POWER_UP, PMR_POR_WAIT, PMR_MON_HOLD, PMR_RUN} pmr_state_e;
endpackage

// ===== rtl/pmr_ram.sv
// Small data memory that reset does not touch.
`timescale 1ns/100ps
module pmr_ram #(
  parameter int unsigned AW = 4,
  parameter int unsigned DW = 8
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

// ===== rtl/pmr_seq.sv
// Power-on and supply-monitor reset sequencer with reset-state defaults.
`timescale 1ns/100ps
// How it works
// (RULE1) Reset halts execution, resets registers, forces ports and disables interrupts and timers.
// (RULE2) Reset leaves data memory intact while the stack pointer is reinitialised.
// (RULE3) Port latches read all ones, open drain, weak pullups on during and after reset.
// (RULE4) Power-on and monitor resets drive the reset pin low for the whole reset.
// (RULE5) Leaving reset clears the program counter and selects the internal oscillator.
// (RULE6) The watchdog comes up enabled, ticking at the system clock divided by twelve.
// (RULE7) Fetch starts at address zero after every reset.
// (RULE8) Power-up holds reset until supply is above threshold, then waits the release delay.
// (RULE9) Leaving power-on or monitor reset sets the power-on cause flag.
// (RULE10) Any other reset clears the power-on cause flag.
// (RULE11) Power-on forces the monitor enable on; other resets keep it.
// (RULE12) Supply below threshold drives the pin low and holds reset until it recovers.
// (RULE13) Monitor reset release has no power-on delay.
// (RULE14) Software enables the monitor, waits, then selects it as reset source.
// (RULE15) The monitor resets the system only when enabled and selected as a source.
// (RULE16) Reset asserts at once and releases on a clock edge.
module pmr_seq
  import pmr_pkg::*;
#(
  parameter int unsigned POR_CYCLES = POR_DELAY_CYC,
  parameter int unsigned RAM_AW     = 4
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        supply_ok,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic             core_rst,
  output logic             rst_pin_o,
  output logic             rst_pin_oe,
  output logic      [7:0]  port_latch,
  output logic             port_open_drain,
  output logic             weak_pullup_en,
  output logic             irq_enable,
  output logic             timers_enable,
  output logic      [15:0] pc_start,
  output logic      [7:0]  stack_ptr,
  output logic      [1:0]  clk_src,
  output logic             wdt_enable,
  output logic             wdt_tick
);
  initial begin
    if (POR_CYCLES < 1 || POR_CYCLES > 2**24 - 1 || RAM_AW < 1 || RAM_AW > 4) begin
      $error("pmr_seq: unsupported parameter value");
    end
  end

  pmr_state_e  state;
  logic [23:0] por_cnt;
  logic [2:0]  sync;
  logic        supply_s;
  logic        mon_en;
  logic        mon_sel;
  logic        power_on_cause_flag;
  logic        sw_rst_req;
  logic        mon_trip;
  logic        in_reset;
  logic [3:0]  wdt_cnt;
  logic [7:0]  ram_q;
  logic [RAM_AW-1:0] ram_addr;

  // Three stages; a change counts once the last two agree.
  always_ff @(posedge clk) begin
    sync <= {sync[1:0], supply_ok};
    if (sync[2] == sync[1]) begin
      supply_s <= sync[2];
    end
  end

  assign mon_trip = mon_en && mon_sel && !supply_s; // see (RULE15)

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state   <= PMR_POWER_UP;
      por_cnt <= '0;
    end else begin
      unique case (state)
        PMR_POWER_UP: begin
          if (supply_s) begin // see (RULE8)
            state   <= PMR_POR_WAIT;
            por_cnt <= '0;
          end
        end
        PMR_POR_WAIT: begin
          if (!supply_s) begin
            state <= PMR_POWER_UP;
          end else if (por_cnt == 24'(POR_CYCLES - 1)) begin // see (RULE8)
            state <= PMR_RUN;
          end else begin
            por_cnt <= por_cnt + 24'h000001;
          end
        end
        PMR_MON_HOLD: begin
          if (supply_s) begin
            state <= PMR_RUN; // see (RULE13)
          end
        end
        PMR_RUN: begin
          if (mon_trip) begin
            state <= PMR_MON_HOLD; // see (RULE12)
          end
        end
      endcase
    end
  end

  // Reset rises combinationally on a monitor trip and falls on an edge.
  assign in_reset   = (state != PMR_RUN) || mon_trip || sw_rst_req; // see (RULE16)
  assign core_rst   = in_reset; // see (RULE1)
  assign rst_pin_o  = 1'b0;
  assign rst_pin_oe = (state != PMR_RUN) || mon_trip; // see (RULE4) (RULE12)

  // Monitor enable and cause flag.
  always_ff @(posedge clk) begin
    if (sys_rst || state == PMR_POWER_UP) begin
      mon_en              <= 1'b1; // see (RULE11)
      mon_sel             <= 1'b1;
      power_on_cause_flag <= 1'b0;
    end else if (state == PMR_POR_WAIT || state == PMR_MON_HOLD) begin
      power_on_cause_flag <= 1'b1; // see (RULE9)
    end else if (sw_rst_req) begin
      power_on_cause_flag <= 1'b0; // see (RULE10)
      mon_sel             <= 1'b0;
    end else if (reg_wr && reg_addr == ADDR_MON_CTRL) begin
      mon_en <= reg_wdata[MON_EN_BIT];
    end else if (reg_wr && reg_addr == ADDR_RST_SRC) begin
      mon_sel <= reg_wdata[POR_FLAG_BIT]; // see (RULE14)
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sw_rst_req <= 1'b0;
    end else begin
      sw_rst_req <= reg_wr && reg_addr == ADDR_SW_RESET && reg_wdata[SW_RST_BIT];
    end
  end

  // Reset-state defaults; memory is not cleared.
  always_ff @(posedge clk) begin
    if (in_reset) begin
      port_latch      <= PORT_LATCH_RST; // see (RULE3)
      port_open_drain <= 1'b1;
      weak_pullup_en  <= 1'b1;
      irq_enable      <= 1'b0;
      timers_enable   <= 1'b0;
      pc_start        <= PC_RST; // see (RULE5) (RULE7)
      stack_ptr       <= SP_RST; // see (RULE2)
      clk_src         <= CLK_SRC_INT_OSC;
      wdt_enable      <= 1'b1; // see (RULE6)
      ram_addr        <= ram_addr;
    end else if (reg_wr && reg_addr == ADDR_RAM_ADDR) begin
      ram_addr <= reg_wdata[RAM_AW-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (in_reset || !wdt_enable) begin
      wdt_cnt  <= '0;
      wdt_tick <= 1'b0;
    end else begin
      wdt_tick <= (wdt_cnt == 4'(WDT_DIV - 1)); // see (RULE6)
      wdt_cnt  <= (wdt_cnt == 4'(WDT_DIV - 1)) ? 4'h0 : wdt_cnt + 4'h1;
    end
  end

  pmr_ram #(.AW(RAM_AW), .DW(8)) u_ram (
    .clk  (clk),
    .we   (reg_wr && reg_addr == ADDR_RAM_DATA && !in_reset), // see (RULE2)
    .addr (ram_addr),
    .wdata(reg_wdata),
    .rdata(ram_q)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_MON_CTRL: reg_rdata <= {mon_en, supply_s, 6'h00};
        ADDR_RST_SRC:  reg_rdata <= {6'h00, power_on_cause_flag, 1'b0};
        ADDR_RAM_ADDR: reg_rdata <= 8'(ram_addr);
        ADDR_RAM_DATA: reg_rdata <= ram_q;
        ADDR_STATUS:   reg_rdata <= {5'h00, in_reset, 2'(state)};
        default:       reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  a_pin_during_reset: assert property (@(posedge clk) disable iff (sys_rst)
    (state != PMR_RUN) |-> rst_pin_oe && core_rst) else $error("pin not low in reset"); // see (RULE4)
  a_por_wait_len: assert property (@(posedge clk) disable iff (sys_rst)
    (state == PMR_POR_WAIT && supply_s && por_cnt != 24'(POR_CYCLES - 1)) |=> state == PMR_POR_WAIT)
    else $error("power-on wait left early"); // see (RULE8)
  a_mon_no_delay: assert property (@(posedge clk) disable iff (sys_rst)
    (state == PMR_MON_HOLD && supply_s) |=> state == PMR_RUN) else $error("monitor release delayed"); // see (RULE13)
  a_flag_set_exit: assert property (@(posedge clk) disable iff (sys_rst)
    (state == PMR_MON_HOLD) |=> power_on_cause_flag) else $error("cause flag not set"); // see (RULE9)
  a_flag_sw_clear: assert property (@(posedge clk) disable iff (sys_rst)
    (state == PMR_RUN && sw_rst_req) |=> !power_on_cause_flag) else $error("cause flag kept"); // see (RULE10)
  a_mon_en_kept: assert property (@(posedge clk) disable iff (sys_rst)
    (sw_rst_req && state == PMR_RUN) |=> mon_en == $past(mon_en)) else $error("monitor enable changed"); // see (RULE11)
  a_mon_trip_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (state == PMR_RUN && mon_trip) |-> core_rst ##1 state == PMR_MON_HOLD) else $error("no monitor hold"); // see (RULE12)
  a_port_defaults: assert property (@(posedge clk) disable iff (sys_rst)
    in_reset |=> port_latch == PORT_LATCH_RST && pc_start == PC_RST && wdt_enable && !irq_enable)
    else $error("reset defaults wrong"); // see (RULE3)

  // The pin is let go as soon as the core runs with no trip pending.
  a_pin_released: assert property (@(posedge clk) disable iff (sys_rst)
    (state == PMR_RUN && !mon_trip) |-> !rst_pin_oe) else $error("pin held while running"); // see (RULE4)
  a_trip_needs_sel: assert property (@(posedge clk) disable iff (sys_rst)
    (state == PMR_RUN && !(mon_en && mon_sel)) |=> state != PMR_MON_HOLD)
    else $error("monitor reset while not selected"); // see (RULE15)
  a_sw_rst_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    sw_rst_req |-> core_rst) else $error("software reset not applied"); // see (RULE1)
  a_ram_blocked: assert property (@(posedge clk) disable iff (sys_rst)
    in_reset |-> !u_ram.we) else $error("memory written in reset"); // see (RULE2)
  a_wdt_off_rst: assert property (@(posedge clk) disable iff (sys_rst)
    in_reset |=> !wdt_tick && wdt_cnt == 4'h0) else $error("watchdog ran in reset"); // see (RULE6)
  a_rdata_idle: assert property (@(posedge clk) disable iff (sys_rst)
    !reg_rd |=> reg_rdata == 8'h00) else $error("read data outside its cycle");
endmodule

// ===== tb/pmr_board.sv
// Board model for the reset pin and the supply comparator.
`timescale 1ns/100ps
module pmr_board (
  input  wire logic pin_o,
  input  wire logic pin_oe,
  input  wire logic supply_up,
  output logic      pin_n,
  output logic      supply_ok
);
  // The pin has a board pullup, so it reads high whenever the device lets go.
  assign pin_n     = pin_oe ? pin_o : 1'b1;
  assign supply_ok = supply_up;
endmodule

// ===== tb/power_on_supply_monitor_reset_tb.sv
// Self-checking bench for the reset sequencer.
`timescale 1ns/100ps
module power_on_supply_monitor_reset_tb;
  import pmr_pkg::*;
  logic        clk = 0, sys_rst = 1, sup = 0, reg_wr = 0, reg_rd = 0;
  logic [3:0]  reg_addr = 0;
  logic [7:0]  reg_wdata = 0, reg_rdata, port_latch, stack_ptr, d, ra, rdat;
  logic [15:0] pc_start;
  logic [1:0]  clk_src;
  logic        core_rst, rst_pin_o, rst_pin_oe, pin_n, supply_ok, port_open_drain, weak_pullup_en;
  logic        irq_enable, timers_enable, wdt_enable, wdt_tick;
  int          mismatches = 0, cmp_count = 0, n;
  always #20 clk = ~clk;
  pmr_board i_board (.pin_o(rst_pin_o), .pin_oe(rst_pin_oe), .supply_up(sup), .pin_n, .supply_ok);
  pmr_seq #(.POR_CYCLES(8)) i_dut (.clk, .sys_rst, .supply_ok, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .core_rst, .rst_pin_o, .rst_pin_oe, .port_latch, .port_open_drain, .weak_pullup_en,
    .irq_enable, .timers_enable, .pc_start, .stack_ptr, .clk_src, .wdt_enable, .wdt_tick);
  function automatic logic [7:0] ctl_exp(input logic en, input logic st);
    return {en, st, 6'h00};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge clk) reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk) reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic wait_rst(input logic v, input int lim, output int c);
    c = 0;
    while (core_rst !== v && c < lim) begin
      @(posedge clk);
      #1 c++;
    end
  endtask
  task automatic dflt();
    chk({port_latch, port_open_drain, weak_pullup_en, irq_enable, timers_enable},
        {PORT_LATCH_RST, 4'b1100});
    chk({pc_start, stack_ptr, clk_src, wdt_enable}, {PC_RST, SP_RST, CLK_SRC_INT_OSC, 1'b1});
  endtask
  task automatic sw_reset();
    wr(ADDR_SW_RESET, 8'h10);
    wait_rst(1, 4, n);
    chk(n < 4, 1);
    wait_rst(0, 4, n);
  endtask
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    stop_test();
  end
  initial begin
    void'($urandom(10));
    for (int p = 0; p < 2; p++) begin
      sys_rst <= 1'b1;
      sup     <= 1'b0;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (20) @(posedge clk);
      #1 chk({core_rst, pin_n}, 2'b10);
      dflt();
      @(posedge clk) sup <= 1'b1;
      repeat (8) @(posedge clk);
      #1 chk(core_rst, 1);
      wait_rst(0, 40, n);
      chk({n < 40, pin_n}, 2'b11);
      dflt();
      rd(ADDR_RST_SRC, d);
      chk(d[POR_FLAG_BIT], 1);
      rd(ADDR_MON_CTRL, d);
      chk(d, ctl_exp(1, 1));
      if (p == 0) wr(ADDR_MON_CTRL, 8'h00);
    end
    rd(4'hf, d);
    chk(d, 8'h00);
    ra = $urandom;
    rdat = $urandom;
    wr(ADDR_RAM_ADDR, {4'h0, ra[3:0]});
    wr(ADDR_RAM_DATA, rdat);
    sw_reset();
    dflt();
    repeat (2) rd(ADDR_RAM_DATA, d);
    chk(d, rdat);
    rd(ADDR_RST_SRC, d);
    chk(d[POR_FLAG_BIT], 0);
    rd(ADDR_MON_CTRL, d);
    chk(d[MON_EN_BIT], 1);
    wr(ADDR_MON_CTRL, 8'h80);
    repeat (4) @(posedge clk);
    wr(ADDR_RST_SRC, 8'h02);
    @(posedge clk) sup <= 1'b0;
    wait_rst(1, 8, n);
    chk({n < 8, pin_n}, 2'b10);
    @(posedge clk) sup <= 1'b1;
    wait_rst(0, 8, n);
    chk(n < 8, 1);
    rd(ADDR_RST_SRC, d);
    chk(d[POR_FLAG_BIT], 1);
    repeat (2) begin
      n = 0;
      do begin
        @(posedge clk);
        #1 n++;
      end while (wdt_tick !== 1'b1 && n < 30);
    end
    chk(n, WDT_DIV);
    wr(ADDR_MON_CTRL, 8'h00);
    sw_reset();
    rd(ADDR_MON_CTRL, d);
    chk(d[MON_EN_BIT], 0);
    @(posedge clk) sup <= 1'b0;
    repeat (10) @(posedge clk);
    #1 chk(core_rst, 0);
    stop_test();
  end
endmodule
